// ---- hw/afei_pkg.sv ----
// afei_pkg: register map, field positions and timing for the audio event interrupt block
// assumes a 20 MHz core clock and an 8-bit register port of the surrounding device
package afei_pkg;
  localparam int unsigned                  CLOCK_HZ          = 20_000_000;
  localparam int unsigned                  PULSE_WIDTH_US    = 2000;  // typical 2 ms high time
  localparam int unsigned                  PULSE_PERIOD_US   = 4000;  // typical 4 ms repeat period
  localparam int unsigned                  PULSE_WIDTH_CYC   = (CLOCK_HZ / 1000) * PULSE_WIDTH_US / 1000;
  localparam int unsigned                  PULSE_PERIOD_CYC  = (CLOCK_HZ / 1000) * PULSE_PERIOD_US / 1000;
  localparam int unsigned                  TIMER_WIDTH       = 17;

  localparam logic [7:0]                   ADDR_STICKY       = 8'h2C;
  localparam logic [7:0]                   ADDR_RSVD_STICKY  = 8'h2D;
  localparam logic [7:0]                   ADDR_LIVE         = 8'h2E;
  localparam logic [7:0]                   ADDR_RSVD_LIVE    = 8'h2F;
  localparam logic [7:0]                   ADDR_FIRST_CTRL   = 8'h30;
  localparam logic [7:0]                   ADDR_SECOND_CTRL  = 8'h31;

  // sticky and live status bit positions
  localparam int unsigned                  BIT_SHORT_LEFT    = 7;
  localparam int unsigned                  BIT_SHORT_RIGHT   = 6;
  localparam int unsigned                  BIT_BUTTON        = 5;
  localparam int unsigned                  BIT_HEADSET       = 4;
  localparam int unsigned                  BIT_POWER_LEFT    = 3;
  localparam int unsigned                  BIT_POWER_RIGHT   = 2;
  localparam logic [7:0]                   STICKY_MASK       = 8'hFC;

  // control register bit positions
  localparam int unsigned                  CTL_INSERT_EN     = 7;
  localparam int unsigned                  CTL_BUTTON_EN     = 6;
  localparam int unsigned                  CTL_POWER_EN      = 5;
  localparam int unsigned                  CTL_SHORT_EN      = 3;
  localparam int unsigned                  CTL_OVERFLOW_EN   = 2;
  localparam int unsigned                  CTL_REPEAT        = 0;
  localparam logic [7:0]                   CTRL_WRITE_MASK   = 8'hED;
  localparam logic [7:0]                   CTRL_RESET        = 8'h00;
  localparam logic [7:0]                   BYTE_ZERO         = 8'h00;

  // overflow flag register kept elsewhere; its three flags are gathered here
  localparam logic [2:0]                   OVERFLOW_NONE     = 3'h0;

  localparam int unsigned                  NUM_OUTPUTS       = 2;

  typedef enum logic [1:0] {PULSE_IDLE, PULSE_HIGH, PULSE_LOW} afei_pulse_type;
endpackage : afei_pkg

// ---- hw/afei_top.sv ----
// afei_top: sticky and live event flags, two interrupt control registers, two pulse outputs
// assumes event inputs are synchronous levels from the detectors and a simple
// byte register port (address, write strobe, read strobe, data) from the control bus slave
//
// Overview of operation
// - Left headphone or class-D short sets sticky bit 7.
// - Right headphone or class-D short sets sticky bit 6.
// - Headset button press sets sticky bit 5; reset value undefined.
// - Headset insertion or removal sets sticky bit 4; reset value undefined.
// - Left power strictly above compressor threshold sets sticky bit 3.
// - Right power above threshold sets sticky bit 2; bits 1..0 read zero.
// - Sticky flags read-only, cleared by reading, set again only by new events.
// - Live bits 7 and 6 show present left and right shorts, unlatched.
// - Live bit 4 one after insertion, zero after removal; bit 5 button state.
// - Live bits 3 and 2 high while channel power exceeds threshold.
// - Control bit 7 enables headset insertion source; reset clears it.
// - Control bit 6 enables button press source.
// - Control bit 5 enables compressor signal-power source.
// - Control bit 3 enables short-circuit source; bits 4 and 1 reserved.
// - Control bit 2 lets converter overflow raise the output.
// - Repeat bit zero: one active-high pulse of 2 ms per event.
// - Repeat bit one: 2 ms pulses every 4 ms until sticky register read.
// - Reading sticky register stops repeat pulse trains on both outputs.
// - Second output has its own independent control register.
// - Left, right and shifter overflow sticky flags form the overflow source.
`timescale 1ns/1ps
`default_nettype none

module afei_top
  import afei_pkg::*;
#(
  parameter int unsigned PULSE_WIDTH  = PULSE_WIDTH_CYC,
  parameter int unsigned PULSE_PERIOD = PULSE_PERIOD_CYC
) (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  // register port
  input  wire logic [7:0] i_reg_address,
  input  wire logic       i_reg_write,
  input  wire logic [7:0] i_reg_write_data,
  input  wire logic       i_reg_read,
  output var  logic [7:0] o_reg_read_data,
  // detector levels
  input  wire logic       i_short_left,
  input  wire logic       i_short_right,
  input  wire logic       i_button_pressed,
  input  wire logic       i_headset_present,
  input  wire logic       i_power_above_left,
  input  wire logic       i_power_above_right,
  // overflow event pulses
  input  wire logic       i_overflow_left,
  input  wire logic       i_overflow_right,
  input  wire logic       i_overflow_shifter,
  // interrupt pins
  output var  logic       o_first_interrupt_output,
  output var  logic       o_second_interrupt_output
);
  import afei_pkg::*;

  // register map seen from the host side
  //   0x2C sticky event flags, read clears them
  //   0x2D reserved, reads zero, writes dropped
  //   0x2E live detector levels, read only
  //   0x2F reserved, reads zero, writes dropped
  //   0x30 first output control, read and write
  //   0x31 second output control, read and write
  // anything else on the address bus reads zero
  //
  // sticky and live layout, bit 7 down to bit 2
  //   7 left driver short
  //   6 right driver short
  //   5 headset button
  //   4 headset insertion or removal
  //   3 left channel power above compressor threshold
  //   2 right channel power above compressor threshold
  //   1..0 reserved, always zero
  //
  // control layout, shared by both outputs
  //   7 insertion source enable
  //   6 button source enable
  //   5 signal-power source enable
  //   4 reserved, forced zero on write
  //   3 short-circuit source enable
  //   2 overflow source enable
  //   1 reserved, forced zero on write
  //   0 repeat mode select
  //
  // reserved control bits are masked on write so a
  // readback never shows a bit that has no effect

  // registers
  logic [7:0]                  sticky;
  logic [7:0]                  first_ctrl;
  logic [7:0]                  second_ctrl;
  logic [2:0]                  overflow_sticky;
  logic [5:0]                  live_prev;
  logic                        overflow_prev;
  logic [7:0]                  read_data;
  logic [NUM_OUTPUTS-1:0]      irq_pin;

  // live level vector in bit order 7..2
  logic [5:0] live_now;
  logic [5:0] rise;
  logic [5:0] fall;
  logic [7:0] live_byte;
  logic [7:0] event_byte;
  logic [7:0] next_sticky;
  logic       sticky_read;
  logic       overflow_event;
  logic [2:0] next_overflow;
  logic       insert_event;
  logic       first_ctrl_write;
  logic       second_ctrl_write;

  assign live_now = {i_short_left, i_short_right, i_button_pressed,
                     i_headset_present, i_power_above_left, i_power_above_right};
  assign rise     = live_now & ~live_prev;
  assign fall     = ~live_now & live_prev;
  assign live_byte = {live_now, 2'h0};

  // event detection notes
  // detectors deliver levels, so an event is a change
  // seen against the value of the previous cycle;
  // a level that stays high raises its flag only once,
  // which keeps a held short from flooding the host
  // headset presence counts in both directions for the
  // sticky flag, but only insertion feeds the outputs
  // live_prev clears in reset: a level already high at
  // release is taken as a fresh event one edge later
  // limitation: a glitch shorter than one clock period
  // is missed, the detectors must stretch their levels

  // events: rising edges, plus headset change in either direction
  assign event_byte[BIT_SHORT_LEFT]  = rise[5];
  assign event_byte[BIT_SHORT_RIGHT] = rise[4];
  assign event_byte[BIT_BUTTON]      = rise[3];
  assign event_byte[BIT_HEADSET]     = rise[2] | fall[2];
  assign event_byte[BIT_POWER_LEFT]  = rise[1];
  assign event_byte[BIT_POWER_RIGHT] = rise[0];
  assign event_byte[1:0]             = 2'h0;
  assign insert_event                = rise[2];

  // read clears, but an event in the same cycle wins
  assign sticky_read       = i_reg_read && (i_reg_address == ADDR_STICKY);
  assign first_ctrl_write  = i_reg_write && (i_reg_address == ADDR_FIRST_CTRL);
  assign second_ctrl_write = i_reg_write && (i_reg_address == ADDR_SECOND_CTRL);
  assign next_sticky = ((sticky_read ? BYTE_ZERO : sticky) | event_byte) & STICKY_MASK;

  // overflow notes
  // the converter flags live in a register outside this
  // block; only their union matters for the outputs
  // the local copies are sticky so a one-cycle overflow
  // pulse still leads to an interrupt pulse
  // a new pulse needs the copies cleared first, which the
  // sticky read does; until then further overflows are
  // folded into the pulse already given

  // overflow sticky flags held here, cleared by the same sticky read
  assign next_overflow  = (sticky_read ? OVERFLOW_NONE : overflow_sticky)
                          | {i_overflow_left, i_overflow_right, i_overflow_shifter};
  assign overflow_event = (|overflow_sticky) & ~overflow_prev;

  // event state and registers; the undefined reset of bits 5 and 4 is given zero here
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sticky          <= BYTE_ZERO;
      live_prev       <= 6'h00;
      overflow_sticky <= OVERFLOW_NONE;
      overflow_prev   <= 1'b0;
      first_ctrl      <= CTRL_RESET;
      second_ctrl     <= CTRL_RESET;
    end else begin
      sticky          <= next_sticky;
      live_prev       <= live_now;
      overflow_sticky <= next_overflow;
      overflow_prev   <= |overflow_sticky;
      if (first_ctrl_write) begin
        first_ctrl <= i_reg_write_data & CTRL_WRITE_MASK;
      end
      if (second_ctrl_write) begin
        second_ctrl <= i_reg_write_data & CTRL_WRITE_MASK;
      end
    end
  end

  // read path notes
  // read data is registered and held until the next
  // read strobe, so the host may sample it late
  // the sticky value returned is the one before the
  // clear; an event in the read cycle stays set
  // and shows on the following read instead

  // read mux; reserved and unmapped addresses read zero
  logic [7:0] next_read_data;
  always_comb begin
    next_read_data = BYTE_ZERO;
    unique case (i_reg_address)
      ADDR_STICKY:      next_read_data = sticky;
      ADDR_LIVE:        next_read_data = live_byte;
      ADDR_FIRST_CTRL:  next_read_data = first_ctrl;
      ADDR_SECOND_CTRL: next_read_data = second_ctrl;
      default:          next_read_data = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      read_data <= BYTE_ZERO;
    end else if (i_reg_read) begin
      read_data <= next_read_data;
    end
  end
  assign o_reg_read_data = read_data;

  // one pulse generator per interrupt output
  logic [7:0] ctrl_sel [NUM_OUTPUTS];
  assign ctrl_sel[0] = first_ctrl;
  assign ctrl_sel[1] = second_ctrl;

  // pulse generator notes
  // each output has its own state machine and timer
  // idle: timer held at zero, waiting for a trigger
  // high: pin high, timer counts up to width minus one
  // low: pin low in repeat mode, timer runs on to
  //      period minus one, then the next pulse starts
  // the timer runs from pulse start, so the period is
  // measured rising edge to rising edge
  // triggers while a pulse or train is under way are
  // dropped; the sticky flags still record them
  // a sticky read in the low phase ends the train at
  // once; one in the high phase is remembered and the
  // pulse in progress is finished at full width, so the
  // host never sees a runt pulse
  // clearing the repeat bit also ends a train after the
  // pulse in progress
  // the pin is the registered image of the next state,
  // so it matches the state register cycle for cycle

  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : gen_out
      logic [7:0]             ctl;
      logic                   trigger;
      afei_pulse_type         state;
      afei_pulse_type         next_state;
      logic [TIMER_WIDTH-1:0] timer;
      logic [TIMER_WIDTH-1:0] next_timer;
      logic                   width_done;
      logic                   period_done;
      logic                   stop_pending;
      logic                   next_stop_pending;
      logic                   pin;

      assign ctl     = ctrl_sel[g];
      // enabled new events combined by OR
      assign trigger = (ctl[CTL_INSERT_EN]   & insert_event)
                     | (ctl[CTL_BUTTON_EN]   & event_byte[BIT_BUTTON])
                     | (ctl[CTL_POWER_EN]    & (event_byte[BIT_POWER_LEFT]
                                              | event_byte[BIT_POWER_RIGHT]))
                     | (ctl[CTL_SHORT_EN]    & (event_byte[BIT_SHORT_LEFT]
                                              | event_byte[BIT_SHORT_RIGHT]))
                     | (ctl[CTL_OVERFLOW_EN] & overflow_event);

      // counter limits from clock rate; timer counts whole period from pulse start
      assign width_done  = (timer == TIMER_WIDTH'(PULSE_WIDTH - 1));
      assign period_done = (timer == TIMER_WIDTH'(PULSE_PERIOD - 1));

      always_comb begin
        next_state = state;
        next_timer = timer + TIMER_WIDTH'(1);
        unique case (state)
          PULSE_IDLE: begin
            next_timer = '0;
            if (trigger) begin
              next_state = PULSE_HIGH;
            end
          end
          PULSE_HIGH: begin
            if (width_done) begin
              next_state = (ctl[CTL_REPEAT] && !stop_pending) ? PULSE_LOW : PULSE_IDLE;
            end
          end
          PULSE_LOW: begin
            if (sticky_read || !ctl[CTL_REPEAT]) begin
              next_state = PULSE_IDLE;
              next_timer = '0;
            end else if (period_done) begin
              next_state = PULSE_HIGH;
              next_timer = '0;
            end
          end
          // unused state code falls back to idle
          default: begin
            next_state = PULSE_IDLE;
            next_timer = '0;
          end
        endcase
        // a read in the last cycle of the high phase of a train ends it after this pulse
        if (state == PULSE_HIGH && sticky_read && width_done) begin
          next_state = PULSE_IDLE;
        end
      end

      // read seen mid-pulse is held until the pulse ends;
      // a read in the trigger cycle is ignored since the
      // event that starts the pulse survives that read
      assign next_stop_pending = (state != PULSE_IDLE) && (next_state != PULSE_IDLE)
                               && (stop_pending || sticky_read);

      always_ff @(posedge i_clock) begin
        if (i_reset) begin
          state        <= PULSE_IDLE;
          timer        <= '0;
          stop_pending <= 1'b0;
          pin          <= 1'b0;
        end else begin
          state        <= next_state;
          timer        <= next_timer;
          stop_pending <= next_stop_pending;
          pin          <= (next_state == PULSE_HIGH);
        end
      end
      assign irq_pin[g] = pin;
    end
  endgenerate

  assign o_first_interrupt_output  = irq_pin[0];
  assign o_second_interrupt_output = irq_pin[1];
endmodule : afei_top

`default_nettype wire

// ---- testbench/afei_host.sv ----
// afei_host: host side watching both interrupt pins
// assumes pins are sampled on the core clock
`timescale 1ns/1ps
`default_nettype none
module afei_host (
  input  wire logic       i_clock, i_reset, i_first, i_second,
  output var  logic [7:0] o_rises_first, o_rises_second, o_gap
);
  logic [1:0] last;
  logic [7:0] since;
  // pulse counts, and rise-to-rise spacing on the first pin
  always_ff @(posedge i_clock) begin
    last <= {i_first, i_second};
    since <= (i_first && !last[1]) ? 8'h01 : since + 8'h01;
    if (i_reset) begin
      o_rises_first <= 8'h00;
      o_rises_second <= 8'h00;
    end else begin
      if (i_first && !last[1]) o_rises_first <= o_rises_first + 8'h01;
      if (i_second && !last[0]) o_rises_second <= o_rises_second + 8'h01;
    end
    if (i_first && !last[1]) o_gap <= since;
  end
endmodule : afei_host
`default_nettype wire

// ---- testbench/afei_sva.sv ----
// afei_sva: port-level checks of the audio event interrupt block
// assumes one clock, synchronous active-high reset, bound into afei_top
`timescale 1ns/1ps
`default_nettype none
module afei_sva
  import afei_pkg::*;
#(parameter int unsigned PULSE_WIDTH = 4) (
  input wire logic       i_clock, i_reset, i_reg_write, i_reg_read,
  input wire logic [7:0] i_reg_address, i_reg_write_data, o_reg_read_data,
  input wire logic       i_short_left, i_short_right, i_button_pressed, i_headset_present,
  input wire logic       i_power_above_left, i_power_above_right,
  input wire logic       i_overflow_left, i_overflow_right, i_overflow_shifter,
  input wire logic       o_first_interrupt_output, o_second_interrupt_output
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // read and write decodes and the detector vector
  wire logic       rd_s = i_reg_read && (i_reg_address == ADDR_STICKY);
  wire logic       rd_l = i_reg_read && (i_reg_address == ADDR_LIVE);
  wire logic       wr_c = i_reg_write && (i_reg_address == ADDR_FIRST_CTRL);
  wire logic [8:0] det  = {i_short_left, i_short_right, i_button_pressed, i_headset_present,
    i_power_above_left, i_power_above_right, i_overflow_left, i_overflow_right, i_overflow_shifter};
  logic [TIMER_WIDTH-1:0] hi1, hi2;
  // high-time counters; pins are low in reset so no reset branch needed
  always_ff @(posedge i_clock) begin
    hi1 <= o_first_interrupt_output ? hi1 + 1'b1 : '0;
    hi2 <= o_second_interrupt_output ? hi2 + 1'b1 : '0;
  end
  a_sticky_reserved: assert property (rd_s |=> o_reg_read_data[1:0] == 2'h0)
    else $error("sticky low bits not zero");
  a_live_shorts: assert property (rd_l |=> o_reg_read_data[7:6] == $past(det[8:7]))
    else $error("live short bits wrong");
  a_live_headset: assert property (rd_l |=> o_reg_read_data[5:4] == $past(det[6:5]))
    else $error("live headset bits wrong");
  a_live_power: assert property (rd_l |=> o_reg_read_data[3:2] == $past(det[4:3]))
    else $error("live power bits wrong");
  a_first_width: assert property ($fell(o_first_interrupt_output) |-> hi1 == TIMER_WIDTH'(PULSE_WIDTH))
    else $error("first pulse width wrong");
  a_second_width: assert property ($fell(o_second_interrupt_output) |-> hi2 == TIMER_WIDTH'(PULSE_WIDTH))
    else $error("second pulse width wrong");
  a_ctrl_readback: assert property (wr_c ##1 (i_reg_read && i_reg_address == ADDR_FIRST_CTRL)
    |=> o_reg_read_data == ($past(i_reg_write_data, 2) & CTRL_WRITE_MASK)) else $error("control readback wrong");
  a_sticky_reread: assert property (rd_s && $stable(det) && !$past(i_reset) ##1 rd_s && $stable(det)
    |=> o_reg_read_data == 8'h00) else $error("sticky not cleared by read");
  c_first: cover property ($rose(o_first_interrupt_output));
  c_second: cover property ($rose(o_second_interrupt_output));
  c_flag: cover property (rd_s ##1 o_reg_read_data != 8'h00);
endmodule : afei_sva
bind afei_top afei_sva #(.PULSE_WIDTH(PULSE_WIDTH)) u_afei_sva (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
// testbench: register-port sequences against the audio event interrupt block
// assumes short pulse timing parameters so each step ends in a few cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import afei_pkg::*;
  localparam int unsigned PP = 8;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, p1, p2;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r1, r2, gap, b1, b2;
  logic [8:0] det = 9'h000, prev = 9'h000;
  int         fail_count = 0, n_checks = 0;
  initial forever #25 clk = ~clk;
  afei_top #(.PULSE_WIDTH(4), .PULSE_PERIOD(PP)) u_afei_top (.i_clock(clk), .i_reset(rst),
    .i_reg_address(addr), .i_reg_write(wr), .i_reg_write_data(wdata), .i_reg_read(rd),
    .o_reg_read_data(rdata), .i_short_left(det[8]), .i_short_right(det[7]), .i_button_pressed(det[6]),
    .i_headset_present(det[5]), .i_power_above_left(det[4]), .i_power_above_right(det[3]),
    .i_overflow_left(det[2]), .i_overflow_right(det[1]), .i_overflow_shifter(det[0]),
    .o_first_interrupt_output(p1), .o_second_interrupt_output(p2));
  afei_host u_afei_host (.i_clock(clk), .i_reset(rst), .i_first(p1), .i_second(p2),
    .o_rises_first(r1), .o_rises_second(r2), .o_gap(gap));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // strobes stay up between calls so back-to-back accesses never toggle twice
  task idle(input int n);
    wr = 1'b0;
    rd = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle
  task wrb(input logic [7:0] a, d);
    rd = 1'b0;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
  endtask : wrb
  task rdb(input logic [7:0] a, e);
    wr = 1'b0;
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    check(rdata, e);
  endtask : rdb
  // one event step: configure, raise detectors, drop overflow pulses, read back
  task step(input logic [7:0] c1, c2, input logic [8:0] v, input logic [1:0] n);
    logic [7:0] s1, s2;
    s1 = r1;
    s2 = r2;
    wrb(ADDR_FIRST_CTRL, c1);
    wrb(ADDR_SECOND_CTRL, c2);
    det = v;
    idle(2);
    det = v & 9'h1F8;
    idle(10);
    rdb(ADDR_LIVE, {v[8:3], 2'h0});
    rdb(ADDR_STICKY, {v[8:6] & ~prev[8:6], v[5] ^ prev[5], v[4:3] & ~prev[4:3], 2'h0});
    rdb(ADDR_STICKY, 8'h00);
    check(r1 - s1, {7'h00, n[1]});
    check(r2 - s2, {7'h00, n[0]});
    prev = v & 9'h1F8;
  endtask : step
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    close_out();
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rdb(ADDR_FIRST_CTRL, CTRL_RESET);
    rdb(ADDR_SECOND_CTRL, CTRL_RESET);
    rdb(ADDR_STICKY, 8'h00);
    rdb(ADDR_RSVD_LIVE, 8'h00);
    rdb(ADDR_RSVD_STICKY, 8'h00);
    wrb(ADDR_LIVE, 8'hFF);
    rdb(ADDR_LIVE, 8'h00);
    rdb(8'h40, 8'h00);
    wrb(ADDR_FIRST_CTRL, 8'hFF);
    rdb(ADDR_FIRST_CTRL, CTRL_WRITE_MASK);
    step(8'h40, 8'h08, 9'h040, 2'h2);
    step(8'h40, 8'h08, 9'h100, 2'h1);
    step(8'h40, 8'h08, 9'h080, 2'h1);
    step(8'h80, 8'h00, 9'h020, 2'h2);
    step(8'h80, 8'h00, 9'h000, 2'h0);
    step(8'h20, 8'h20, 9'h010, 2'h3);
    step(8'h20, 8'h00, 9'h008, 2'h2);
    step(8'h04, 8'h00, 9'h004, 2'h2);
    step(8'h00, 8'h04, 9'h002, 2'h1);
    step(8'h04, 8'h04, 9'h001, 2'h3);
    // repeat trains on both pins, stopped by one sticky read
    wrb(ADDR_FIRST_CTRL, 8'h41);
    wrb(ADDR_SECOND_CTRL, 8'h41);
    b1 = r1;
    b2 = r2;
    det = 9'h040;
    // read lands two cycles into the fifth pulse, so the
    // train must finish that pulse and then stop
    idle(4 * PP + 2);
    check({7'h00, (r1 - b1) >= 8'h03}, 8'h01);
    check({7'h00, (r2 - b2) >= 8'h03}, 8'h01);
    check({7'h00, gap >= PP && gap <= PP + 1}, 8'h01);
    rdb(ADDR_STICKY, 8'h20);
    idle(2 * PP);
    b1 = r1;
    b2 = r2;
    idle(3 * PP);
    check(r1, b1);
    check(r2, b2);
    close_out();
  end
endmodule : testbench
`default_nettype wire
